// ==== design/timer8_defines.vh ====
`ifndef TIMER8_DEFINES_VH
`define TIMER8_DEFINES_VH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define CH0_CTRL_ADDR   8'h00
`define CH0_CMP_ADDR    8'h04
`define CH0_DUTY_ADDR   8'h08
`define CH0_COUNT_ADDR  8'h0C
`define CH1_CTRL_ADDR   8'h10
`define CH1_CMP_ADDR    8'h14
`define CH1_DUTY_ADDR   8'h18
`define CH1_COUNT_ADDR  8'h1C
`define CONFIG_ADDR     8'h20

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define CTRL_FLOP_BIT   7
`define CTRL_CKSEL_MSB  6
`define CTRL_CKSEL_LSB  4
`define CTRL_RUN_BIT    3
`define CTRL_MODE_MSB   2
`define CTRL_MODE_LSB   0
`define CONFIG_SLOW_BIT 0

// ----------------------------------------------------------------------
// Modes and clock sources
// ----------------------------------------------------------------------
`define MODE_TIMER      3'h0
`define MODE_DIVIDER    3'h1
`define MODE_PWM        3'h2
`define CKSEL_DIV2K     3'h0
`define CKSEL_DIV128    3'h1
`define CKSEL_DIV32     3'h2
`define CKSEL_DIV8      3'h3
`define CKSEL_LOW       3'h4
`define CKSEL_DIV2      3'h5
`define CKSEL_FULL      3'h6
`define CKSEL_PIN       3'h7

// ----------------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------------
`define CTRL_RESET      8'h00
`define CMP_RESET       8'h00
`define DUTY_RESET      8'h00
`define CONFIG_RESET    8'h00
`define PWM_TOP         8'hFF
`define COUNT_ONE       8'h01
`define AXI_OKAY        2'h0
`define AXI_SLVERR      2'h2
`define WORD_ZERO       32'h0000_0000

`endif

// ==== design/pin_sync3.v ====
`timescale 1ns/1ns
module pin_sync3 (
  input  wire core_clk,
  input  wire resetn,
  input  wire pin,
  output reg  level_r
);
  reg s1_r;
  reg s2_r;
  reg s3_r;

  // A change is accepted only once the second and third stages agree.
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      level_r <= 1'b0;
    end
    else
    begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        level_r <= s3_r;
    end
  end
endmodule

// ==== design/timer8_channel.v ====
`timescale 1ns/1ns
`include "timer8_defines.vh"
module timer8_channel (
  input  wire       core_clk,
  input  wire       resetn,
  input  wire       tick,
  input  wire       event_level,
  input  wire [7:0] ctrl,
  input  wire       ctrl_wr,
  input  wire [7:0] ctrl_wdata,
  input  wire [7:0] cmp,
  input  wire       duty_wr,
  input  wire [7:0] duty_wdata,
  output reg  [7:0] count_r,
  output reg  [7:0] duty_act_r,
  output reg        match_r,
  output reg        div_pin_r,
  output reg        mod_pin_r
);
  reg        ff_r;
  reg  [7:0] shadow_r;
  reg        ev_prev_r;
  reg  [7:0] cnt_nxt;
  reg        ff_nxt;
  reg        match_nxt;
  reg  [7:0] shadow_nxt;
  reg  [7:0] duty_nxt;

  wire       run     = ctrl[`CTRL_RUN_BIT];
  wire [2:0] mode    = ctrl[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
  wire [2:0] cksel   = ctrl[`CTRL_CKSEL_MSB:`CTRL_CKSEL_LSB];
  wire       ev_fall = ev_prev_r & ~event_level;
  wire [7:0] cnt_inc = count_r + `COUNT_ONE;

  always @*
  begin
    cnt_nxt    = count_r;
    ff_nxt     = ff_r;
    match_nxt  = 1'b0;
    shadow_nxt = shadow_r;
    duty_nxt   = duty_act_r;
    if (duty_wr)
    begin
      shadow_nxt = duty_wdata;
      if (!(run && mode == `MODE_PWM))
        duty_nxt = duty_wdata;
    end
    if (!run)
    begin
      // Stopped: the flop keeps its level until the level bit is rewritten.
      cnt_nxt = 8'h00;
      if (ctrl_wr)
        ff_nxt = ctrl_wdata[`CTRL_FLOP_BIT];
    end
    else
    begin
      case (mode)
        `MODE_DIVIDER:
        begin
          if (tick)
          begin
            if (cnt_inc == cmp)
            begin
              cnt_nxt   = 8'h00;
              ff_nxt    = ~ff_r;
              match_nxt = 1'b1;
            end
            else
              cnt_nxt = cnt_inc;
          end
        end
        `MODE_PWM:
        begin
          if (tick)
          begin
            if (count_r == `PWM_TOP)
            begin
              cnt_nxt   = 8'h00;
              ff_nxt    = ff_r ^ (count_r == duty_act_r) ^ 1'b1;
              match_nxt = 1'b1;
              duty_nxt  = shadow_nxt;
            end
            else
            begin
              cnt_nxt = cnt_inc;
              if (count_r == duty_act_r)
                ff_nxt = ~ff_r;
            end
          end
        end
        `MODE_TIMER:
        begin
          if (cksel == `CKSEL_PIN && ev_fall)
          begin
            if (cnt_inc == cmp)
            begin
              cnt_nxt   = 8'h00;
              match_nxt = 1'b1;
            end
            else
              cnt_nxt = cnt_inc;
          end
        end
        default:
        begin
          cnt_nxt = count_r;
        end
      endcase
    end
  end

  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      count_r    <= 8'h00;
      duty_act_r <= `DUTY_RESET;
      shadow_r   <= `DUTY_RESET;
      ff_r       <= 1'b0;
      match_r    <= 1'b0;
      div_pin_r  <= 1'b1;
      mod_pin_r  <= 1'b1;
      ev_prev_r  <= 1'b0;
    end
    else
    begin
      count_r    <= cnt_nxt;
      duty_act_r <= duty_nxt;
      shadow_r   <= shadow_nxt;
      ff_r       <= ff_nxt;
      match_r    <= match_nxt;
      div_pin_r  <= ~ff_nxt;
      mod_pin_r  <= ~ff_nxt;
      ev_prev_r  <= event_level;
    end
  end
endmodule

// ==== design/timer8_event_divider_pwm.v ====
// Behaviour
// - Event mode counts falling edges of input pin.
// - Event match raises interrupt, clears, keeps counting.
// - Event compare value is unbuffered, applies immediately.
// - Divider match toggles flop, clears, interrupts.
// - Divider pin is inverse flop; reset clears.
// - Divider output is square wave, fifty percent.
// - Divider compare value is unbuffered, applies immediately.
// - Stopped counter holds pin until level rewritten.
// - Control bit three runs, bit seven level.
// - Control codes select divide-by-128 divider, start.
// - PWM counts internal clock, eight-bit duty.
// - PWM toggles on duty match and overflow.
// - Modulated pin drives inverse of flop.
// - Reset clears flop in PWM mode.
// - Running duty writes load at period end.
// - Duty read returns effective value until period.
`timescale 1ns/1ns
`include "timer8_defines.vh"
module timer8_event_divider_pwm (
  input  wire        core_clk,
  input  wire        resetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        event_input_pin_0,
  input  wire        event_input_pin_1,
  input  wire        low_freq_clock,
  output wire        divider_output_pin_0,
  output wire        divider_output_pin_1,
  output wire        modulated_output_pin_0,
  output wire        modulated_output_pin_1,
  output wire        match_interrupt_0,
  output wire        match_interrupt_1
);

  // --------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------
  function hit;
    input [7:0] a;
    input [7:0] target;
    begin
      hit = (a[7:2] == target[7:2]);
    end
  endfunction

  function mapped;
    input [7:0] a;
    begin
      mapped = (a[7:6] == 2'h0) && (!a[5] || hit(a, `CONFIG_ADDR));
    end
  endfunction

  // Selects the count tick for a channel from the shared prescaler or the low-frequency clock.
  function sel_tick;
    input [2:0]  sel;
    input [10:0] pre;
    input        fs_t;
    input        fs8_t;
    input        slow;
    begin
      case (sel)
        `CKSEL_DIV2K:  sel_tick = slow ? fs8_t : (&pre[10:0]);
        `CKSEL_DIV128: sel_tick = &pre[6:0];
        `CKSEL_DIV32:  sel_tick = &pre[4:0];
        `CKSEL_DIV8:   sel_tick = &pre[2:0];
        `CKSEL_LOW:    sel_tick = fs_t;
        `CKSEL_DIV2:   sel_tick = pre[0];
        `CKSEL_FULL:   sel_tick = 1'b1;
        default:       sel_tick = 1'b0;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------
  // Bus slave state
  // --------------------------------------------------------------------
  reg        awready_r;
  reg        wready_r;
  reg        bvalid_r;
  reg [1:0]  bresp_r;
  reg        arready_r;
  reg        rvalid_r;
  reg [31:0] rdata_r;
  reg [1:0]  rresp_r;
  reg [7:0]  aw_addr_r;
  reg        aw_held_r;
  reg [7:0]  w_data_r;
  reg        w_strb_r;
  reg        w_held_r;

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  reg [7:0]  ctrl0_r;
  reg [7:0]  ctrl1_r;
  reg [7:0]  cmp0_r;
  reg [7:0]  cmp1_r;
  reg [7:0]  config_r;
  reg [10:0] pre_r;
  reg [2:0]  fs_div_r;
  reg        fs_prev_r;
  reg [31:0] rd_word;

  wire [7:0] count0;
  wire [7:0] count1;
  wire [7:0] duty0;
  wire [7:0] duty1;
  wire       ev_level0;
  wire       ev_level1;
  wire       fs_level;

  wire wr_en   = aw_held_r && w_held_r && !bvalid_r;
  wire wr_ok   = wr_en && mapped(aw_addr_r) && w_strb_r;
  wire wr_ctl0 = wr_ok && hit(aw_addr_r, `CH0_CTRL_ADDR);
  wire wr_ctl1 = wr_ok && hit(aw_addr_r, `CH1_CTRL_ADDR);
  wire wr_dut0 = wr_ok && hit(aw_addr_r, `CH0_DUTY_ADDR);
  wire wr_dut1 = wr_ok && hit(aw_addr_r, `CH1_DUTY_ADDR);
  wire slow    = config_r[`CONFIG_SLOW_BIT];
  wire fs_tick = fs_level && !fs_prev_r;
  wire fs8     = fs_tick && (&fs_div_r);
  wire tick0   = sel_tick(ctrl0_r[`CTRL_CKSEL_MSB:`CTRL_CKSEL_LSB], pre_r, fs_tick, fs8, slow);
  wire tick1   = sel_tick(ctrl1_r[`CTRL_CKSEL_MSB:`CTRL_CKSEL_LSB], pre_r, fs_tick, fs8, slow);

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // --------------------------------------------------------------------
  // Write path
  // --------------------------------------------------------------------
  // Address and data are latched independently, so either may come first.
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= `AXI_OKAY;
      aw_addr_r <= 8'h00;
      aw_held_r <= 1'b0;
      w_data_r  <= 8'h00;
      w_strb_r  <= 1'b0;
      w_held_r  <= 1'b0;
    end
    else
    begin
      if (awready_r && s_axi_awvalid)
      begin
        aw_addr_r <= s_axi_awaddr;
        aw_held_r <= 1'b1;
        awready_r <= 1'b0;
      end
      if (wready_r && s_axi_wvalid)
      begin
        w_data_r <= s_axi_wdata[7:0];
        w_strb_r <= s_axi_wstrb[0];
        w_held_r <= 1'b1;
        wready_r <= 1'b0;
      end
      if (wr_en)
      begin
        bvalid_r  <= 1'b1;
        bresp_r   <= mapped(aw_addr_r) ? `AXI_OKAY : `AXI_SLVERR;
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
      end
      if (bvalid_r && s_axi_bready)
      begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  // Compare values are not buffered; a write acts on the next count.
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      ctrl0_r  <= `CTRL_RESET;
      ctrl1_r  <= `CTRL_RESET;
      cmp0_r   <= `CMP_RESET;
      cmp1_r   <= `CMP_RESET;
      config_r <= `CONFIG_RESET;
    end
    else
    begin
      if (wr_ctl0)
        ctrl0_r <= w_data_r;
      if (wr_ctl1)
        ctrl1_r <= w_data_r;
      if (wr_ok && hit(aw_addr_r, `CH0_CMP_ADDR))
        cmp0_r <= w_data_r;
      if (wr_ok && hit(aw_addr_r, `CH1_CMP_ADDR))
        cmp1_r <= w_data_r;
      if (wr_ok && hit(aw_addr_r, `CONFIG_ADDR))
        config_r <= w_data_r;
    end
  end

  // --------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------
  always @*
  begin
    rd_word = `WORD_ZERO;
    if (hit(s_axi_araddr, `CH0_CTRL_ADDR))
      rd_word = {24'h00_0000, ctrl0_r};
    else if (hit(s_axi_araddr, `CH0_CMP_ADDR))
      rd_word = {24'h00_0000, cmp0_r};
    else if (hit(s_axi_araddr, `CH0_DUTY_ADDR))
      rd_word = {24'h00_0000, duty0};
    else if (hit(s_axi_araddr, `CH0_COUNT_ADDR))
      rd_word = {24'h00_0000, count0};
    else if (hit(s_axi_araddr, `CH1_CTRL_ADDR))
      rd_word = {24'h00_0000, ctrl1_r};
    else if (hit(s_axi_araddr, `CH1_CMP_ADDR))
      rd_word = {24'h00_0000, cmp1_r};
    else if (hit(s_axi_araddr, `CH1_DUTY_ADDR))
      rd_word = {24'h00_0000, duty1};
    else if (hit(s_axi_araddr, `CH1_COUNT_ADDR))
      rd_word = {24'h00_0000, count1};
    else if (hit(s_axi_araddr, `CONFIG_ADDR))
      rd_word = {24'h00_0000, config_r};
  end

  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= `WORD_ZERO;
      rresp_r   <= `AXI_OKAY;
    end
    else
    begin
      if (arready_r && s_axi_arvalid)
      begin
        rdata_r   <= rd_word;
        rresp_r   <= mapped(s_axi_araddr) ? `AXI_OKAY : `AXI_SLVERR;
        rvalid_r  <= 1'b1;
        arready_r <= 1'b0;
      end
      if (rvalid_r && s_axi_rready)
      begin
        rvalid_r  <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Prescaler
  // --------------------------------------------------------------------
  // One free-running divider serves both channels, so their ticks align.
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      pre_r     <= 11'h000;
      fs_div_r  <= 3'h0;
      fs_prev_r <= 1'b0;
    end
    else
    begin
      pre_r     <= pre_r + 11'h001;
      fs_prev_r <= fs_level;
      if (fs_tick)
        fs_div_r <= fs_div_r + 3'h1;
    end
  end

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  // Pulses shorter than a few core cycles are lost here by design.
  pin_sync3 sync_ev0 (
    .core_clk (core_clk),
    .resetn   (resetn),
    .pin      (event_input_pin_0),
    .level_r  (ev_level0)
  );

  pin_sync3 sync_ev1 (
    .core_clk (core_clk),
    .resetn   (resetn),
    .pin      (event_input_pin_1),
    .level_r  (ev_level1)
  );

  pin_sync3 sync_fs (
    .core_clk (core_clk),
    .resetn   (resetn),
    .pin      (low_freq_clock),
    .level_r  (fs_level)
  );

  // --------------------------------------------------------------------
  // Channels
  // --------------------------------------------------------------------
  timer8_channel chan0 (
    .core_clk    (core_clk),
    .resetn      (resetn),
    .tick        (tick0),
    .event_level (ev_level0),
    .ctrl        (ctrl0_r),
    .ctrl_wr     (wr_ctl0),
    .ctrl_wdata  (w_data_r),
    .cmp         (cmp0_r),
    .duty_wr     (wr_dut0),
    .duty_wdata  (w_data_r),
    .count_r     (count0),
    .duty_act_r  (duty0),
    .match_r     (match_interrupt_0),
    .div_pin_r   (divider_output_pin_0),
    .mod_pin_r   (modulated_output_pin_0)
  );

  timer8_channel chan1 (
    .core_clk    (core_clk),
    .resetn      (resetn),
    .tick        (tick1),
    .event_level (ev_level1),
    .ctrl        (ctrl1_r),
    .ctrl_wr     (wr_ctl1),
    .ctrl_wdata  (w_data_r),
    .cmp         (cmp1_r),
    .duty_wr     (wr_dut1),
    .duty_wdata  (w_data_r),
    .count_r     (count1),
    .duty_act_r  (duty1),
    .match_r     (match_interrupt_1),
    .div_pin_r   (divider_output_pin_1),
    .mod_pin_r   (modulated_output_pin_1)
  );

endmodule

// ==== dv/timer8_props.sv ====
`timescale 1ns/1ns
// --------------------------------------------------------------------
// Port checker for the dual timer channel block
// --------------------------------------------------------------------
module timer8_props (
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        divider_output_pin_0,
  input wire logic        divider_output_pin_1,
  input wire logic        modulated_output_pin_0,
  input wire logic        modulated_output_pin_1,
  input wire logic        match_interrupt_0,
  input wire logic        match_interrupt_1
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  AST_RESET_IDLE: assert property (disable iff (1'b0) !resetn |=> divider_output_pin_0 &&
    divider_output_pin_1 && !match_interrupt_0 && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs not idle after reset");
  AST_PIN_PAIR_0: assert property (divider_output_pin_0 == modulated_output_pin_0)
    else $error("channel 0 pins differ");
  AST_PIN_PAIR_1: assert property (divider_output_pin_1 == modulated_output_pin_1)
    else $error("channel 1 pins differ");
  AST_MATCH_PULSE_0: assert property (match_interrupt_0 |=> !match_interrupt_0)
    else $error("channel 0 match longer than one cycle");
  AST_MATCH_PULSE_1: assert property (match_interrupt_1 |=> !match_interrupt_1)
    else $error("channel 1 match longer than one cycle");
  AST_WRITE_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
  AST_BRESP_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && s_axi_rdata[31:8] == 24'h00_0000) else $error("read answer wrong");
  AST_RDATA_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  AST_NO_AR_WHILE_R: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
endmodule

// ==== dv/pulse_source.sv ====
`timescale 1ns/1ns
// --------------------------------------------------------------------
// Event pulse source and free running low clock
// --------------------------------------------------------------------
module pulse_source (
  input  wire logic       core_clk,
  input  wire logic       go,
  input  wire logic [4:0] count,
  output logic            busy,
  output logic            event_input_pin,
  output logic            low_freq_clock
);
  initial
  begin
    low_freq_clock = 1'b0;
    forever #330 low_freq_clock = ~low_freq_clock;
  end

  // Each phase lasts four clocks, twice the minimum, so the synchroniser never drops one.
  initial
  begin
    busy = 1'b0;
    event_input_pin = 1'b1;
    forever
    begin
      @(posedge go);
      busy <= 1'b1;
      repeat (count)
      begin
        repeat (4) @(posedge core_clk);
        event_input_pin <= 1'b0;
        repeat (4) @(posedge core_clk);
        event_input_pin <= 1'b1;
      end
      @(posedge core_clk);
      busy <= 1'b0;
    end
  end
endmodule

// ==== dv/timer8_event_divider_pwm_tb.sv ====
`timescale 1ns/1ns
// --------------------------------------------------------------------
// Self-checking bench
// --------------------------------------------------------------------
module timer8_event_divider_pwm_tb;
  logic        core_clk, resetn, go, busy;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         event_input_pin_0, low_freq_clock, match_interrupt_0, match_interrupt_1;
  wire         divider_output_pin_0, divider_output_pin_1;
  wire         modulated_output_pin_0, modulated_output_pin_1;
  wire         event_input_pin_1 = 1'b1;
  logic [4:0]  pulse_count;
  logic [33:0] e;
  logic [33:0] exp_q[$];
  int          miscompares = 0, tests_run = 0, cyc = 0, low1 = 0, m0 = 0;
  int          t1, t2, t3, s, c, n;

  timer8_event_divider_pwm DUT (.*);
  pulse_source src (.core_clk(core_clk), .go(go), .count(pulse_count), .busy(busy),
    .event_input_pin(event_input_pin_0), .low_freq_clock(low_freq_clock));

  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (!modulated_output_pin_1)
      low1 <= low1 + 1;
    if (match_interrupt_0)
      m0 <= m0 + 1;
    if (s_axi_bvalid && s_axi_bready)
    begin
      e = exp_q.pop_front();
      check("bresp", {s_axi_bresp, 32'h0000_0000}, {e[33:32], 32'h0000_0000});
    end
    if (s_axi_rvalid && s_axi_rready)
    begin
      e = exp_q.pop_front();
      check("read", {s_axi_rresp, s_axi_rdata}, e);
    end
  end

  task automatic check(input string name, input logic [33:0] seen, input logic [33:0] ex);
    tests_run++;
    if (seen !== ex)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, ex, seen);
    end
  endtask

  task automatic summarize;
    if (miscompares == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic step(inout int k);
    @(posedge core_clk);
    k++;
  endtask

  task automatic limit(input int k, input int lim);
    if (k >= lim)
    begin
      miscompares++;
      summarize();
    end
  endtask

  // Each valid drops once its own ready is seen; one idle edge separates two transfers.
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    int k;
    k = 0;
    exp_q.push_back({r, 32'h0000_0000});
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do
    begin
      step(k);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid && k < 50);
    s_axi_bready <= 1'b0;
    limit(k, 50);
    @(posedge core_clk);
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [33:0] ex);
    int k;
    k = 0;
    exp_q.push_back(ex);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do
    begin
      step(k);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid && k < 50);
    s_axi_rready <= 1'b0;
    limit(k, 50);
    @(posedge core_clk);
  endtask

  task automatic wait_pin(output int t);
    int k;
    logic q;
    k = 0;
    q = divider_output_pin_0;
    do step(k); while (divider_output_pin_0 === q && k < 2000);
    t = cyc;
    limit(k, 2000);
  endtask

  task automatic wait_m1(output int t);
    int k;
    k = 0;
    do step(k); while (match_interrupt_1 !== 1'b1 && k < 600);
    t = cyc;
    limit(k, 600);
  endtask

  initial
  begin
    {resetn, go, pulse_count, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    void'($urandom(32'h06ef));
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    check("divider pin", {33'h0_0000_0000, divider_output_pin_0}, 34'h1);
    check("pwm pin", {33'h0_0000_0000, modulated_output_pin_1}, 34'h1);
    for (int a = 0; a <= 36; a += 4)
      axi_rd(8'(a), (a == 36) ? 34'h2_0000_0000 : 34'h0);
    axi_wr(8'h40, 8'h00, 2'h2);
    axi_wr(8'h04, 8'h03, 2'h0);
    axi_wr(8'h00, 8'h11, 2'h0);
    axi_wr(8'h00, 8'h19, 2'h0);
    wait_pin(t1);
    s = m0;
    wait_pin(t2);
    wait_pin(t3);
    check("half period", 34'(t2 - t1), 34'h0180);
    check("half period", 34'(t3 - t2), 34'h0180);
    check("divider matches", 34'(m0 - s), 34'h2);
    axi_wr(8'h00, 8'h11, 2'h0);
    repeat (400) @(posedge core_clk);
    check("held pin", {33'h0_0000_0000, divider_output_pin_0}, 34'h0);
    axi_wr(8'h00, 8'h11, 2'h0);
    check("released pin", {33'h0_0000_0000, divider_output_pin_0}, 34'h1);
    axi_wr(8'h00, 8'h91, 2'h0);
    check("preset pin", {33'h0_0000_0000, divider_output_pin_0}, 34'h0);
    axi_wr(8'h18, 8'h40, 2'h0);
    axi_wr(8'h10, 8'h6A, 2'h0);
    wait_m1(t1);
    s = low1;
    axi_wr(8'h18, 8'h80, 2'h0);
    axi_rd(8'h18, 34'h40);
    wait_m1(t2);
    check("pwm period", 34'(t2 - t1), 34'h0100);
    check("low time", 34'(low1 - s), 34'h00BF);
    s = low1;
    axi_rd(8'h18, 34'h80);
    wait_m1(t3);
    check("low time", 34'(low1 - s), 34'h007F);
    c = $urandom_range(9, 2);
    axi_wr(8'h04, 8'(c), 2'h0);
    axi_wr(8'h00, 8'h78, 2'h0);
    s = m0;
    pulse_count <= 5'(2 * c);
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    n = 0;
    do step(n); while (busy && n < 2000);
    limit(n, 2000);
    repeat (10) @(posedge core_clk);
    check("event matches", 34'(m0 - s), 34'h2);
    axi_wr(8'h10, 8'h62, 2'h0);
    summarize();
  end
endmodule

bind timer8_event_divider_pwm timer8_props props (.core_clk(core_clk), .resetn(resetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .divider_output_pin_0(divider_output_pin_0),
  .divider_output_pin_1(divider_output_pin_1), .modulated_output_pin_0(modulated_output_pin_0),
  .modulated_output_pin_1(modulated_output_pin_1), .match_interrupt_0(match_interrupt_0),
  .match_interrupt_1(match_interrupt_1));
